// ---- src/mcc_pkg.sv ----
package mcc_pkg;

   // ***************************************************************
   // register map
   // ***************************************************************
   localparam logic [7:0] MCC_CSR_INDEX = 8'h2E;
   localparam logic [11:0] MCC_CSR_ADDR = 12'h0B8;
   localparam logic [11:0] MCC_IRQ_STATUS_ADDR = 12'h0C0;
   localparam logic [11:0] MCC_IRQ_MASK_ADDR = 12'h0C4;
   localparam logic [11:0] MCC_POWER_ADDR = 12'h0C8;
   localparam logic [7:0] MCC_CSR_RESET = 8'h00;
   localparam logic [1:0] MCC_IRQ_RESET = 2'h0;

   // ***************************************************************
   // control/status field positions
   // ***************************************************************
   localparam int MCC_CLOCK_OUT_BIT = 7;
   localparam int MCC_SLOW_DIV_LSB = 5;
   localparam int MCC_SLOW_SELECT_BIT = 4;
   localparam int MCC_PERIOD_SEL_LSB = 2;
   localparam int MCC_IRQ_ENABLE_BIT = 1;
   localparam int MCC_FLAG_BIT = 0;

   // irq status/mask bits
   localparam int MCC_IRQ_PERIOD_BIT = 0;
   localparam int MCC_IRQ_WAKE_BIT = 1;

   // ***************************************************************
   // counts
   // ***************************************************************
   localparam int MCC_TB_COUNT_0 = 16000;
   localparam int MCC_TB_COUNT_1 = 32000;
   localparam int MCC_TB_COUNT_2 = 80000;
   localparam int MCC_TB_COUNT_3 = 200000;
   localparam int MCC_TB_WIDTH = 18;
   localparam int MCC_DIV_WIDTH = 4;

   typedef enum logic [1:0] {
      MCC_PWR_RUN,
      MCC_PWR_WAIT,
      MCC_PWR_ACTIVE_HALT,
      MCC_PWR_HALT
   } mcc_power_type;

endpackage : mcc_pkg

// ---- src/mcc_timebase.sv ----
// Our own choice: the APB register port.
`timescale 1ns/1ns
module mcc_timebase #(
   parameter int TB_COUNT_0 = mcc_pkg::MCC_TB_COUNT_0,
   parameter int TB_COUNT_1 = mcc_pkg::MCC_TB_COUNT_1,
   parameter int TB_COUNT_2 = mcc_pkg::MCC_TB_COUNT_2,
   parameter int TB_COUNT_3 = mcc_pkg::MCC_TB_COUNT_3
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic wait_req,
   input wire logic halt_req,
   input wire logic auto_wakeup_halt,
   input wire logic halt_exit_wake,
   input wire logic cpu_irq_mask,
   output logic cpu_clk_en,
   output logic clock_out_enable,
   output logic clock_out_gate,
   output logic period_irq_req,
   output logic period_irq_take,
   output logic irq,
   output logic [1:0] power_state
);

   // ***************************************************************
   // apb decode
   // ***************************************************************
   logic setup;
   logic access;
   logic wr_en;
   logic rd_csr;
   logic regs_live;
   logic hit_csr;
   logic hit_stat;
   logic hit_mask;
   logic hit_pwr;
   logic mapped;

   logic [7:0] csr_q;
   logic [1:0] status_q;
   logic [1:0] mask_q;
   logic [31:0] prdata_q;
   logic pslverr_q;
   logic [1:0] tb_active_q;
   logic [mcc_pkg::MCC_TB_WIDTH-1:0] tb_cnt_q;
   logic [mcc_pkg::MCC_TB_WIDTH-1:0] tb_limit;
   logic tb_run;
   logic tb_done;
   logic [mcc_pkg::MCC_DIV_WIDTH-1:0] div_cnt_q;
   logic [mcc_pkg::MCC_DIV_WIDTH-1:0] div_last;
   logic cpu_clk_en_q;
   logic wake_event;
   mcc_pkg::mcc_power_type pwr_q;
   mcc_pkg::mcc_power_type pwr_d;

   assign setup = psel && !penable;
   assign access = psel && penable;
   assign hit_csr = paddr == mcc_pkg::MCC_CSR_ADDR;
   assign hit_stat = paddr == mcc_pkg::MCC_IRQ_STATUS_ADDR;
   assign hit_mask = paddr == mcc_pkg::MCC_IRQ_MASK_ADDR;
   assign hit_pwr = paddr == mcc_pkg::MCC_POWER_ADDR;
   assign mapped = hit_csr || hit_stat || hit_mask || hit_pwr;
   // writes and the read clear of the flag only act while the core runs or waits
   assign regs_live = (pwr_q == mcc_pkg::MCC_PWR_RUN) ||
                      (pwr_q == mcc_pkg::MCC_PWR_WAIT);
   assign wr_en = access && pwrite && regs_live;
   assign rd_csr = access && !pwrite && hit_csr && regs_live;
   assign pready = 1'b1;
   assign prdata = prdata_q;
   assign pslverr = pslverr_q;

   // ***************************************************************
   // read data, sampled in the setup cycle so the answer is a flop
   // ***************************************************************
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (setup) begin
         pslverr_q <= !mapped;
         if (pwrite || !mapped) begin
            prdata_q <= 32'h0000_0000;
         end else if (hit_csr) begin
            prdata_q <= {24'h00_0000, csr_q};
         end else if (hit_stat) begin
            prdata_q <= {30'h0000_0000, status_q};
         end else if (hit_mask) begin
            prdata_q <= {30'h0000_0000, mask_q};
         end else begin
            prdata_q <= {30'h0000_0000, pwr_q};
         end
      end
   end

   // ***************************************************************
   // control/status register
   // ***************************************************************
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         csr_q <= mcc_pkg::MCC_CSR_RESET;
      end else begin
         if (wr_en && hit_csr) begin
            csr_q[7:1] <= pwdata[7:1];
         end
         // set wins over the clear by read
         if (tb_done) begin
            csr_q[mcc_pkg::MCC_FLAG_BIT] <= 1'b1;
         end else if (rd_csr) begin
            csr_q[mcc_pkg::MCC_FLAG_BIT] <= 1'b0;
         end
      end
   end

   // ***************************************************************
   // interrupt status and mask
   // ***************************************************************
   assign wake_event = (pwr_q != mcc_pkg::MCC_PWR_RUN) &&
                       (pwr_d == mcc_pkg::MCC_PWR_RUN);

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         status_q <= mcc_pkg::MCC_IRQ_RESET;
      end else begin
         if (tb_done) begin
            status_q[mcc_pkg::MCC_IRQ_PERIOD_BIT] <= 1'b1;
         end else if (wr_en && hit_stat &&
                      pwdata[mcc_pkg::MCC_IRQ_PERIOD_BIT]) begin
            status_q[mcc_pkg::MCC_IRQ_PERIOD_BIT] <= 1'b0;
         end
         if (wake_event) begin
            status_q[mcc_pkg::MCC_IRQ_WAKE_BIT] <= 1'b1;
         end else if (wr_en && hit_stat &&
                      pwdata[mcc_pkg::MCC_IRQ_WAKE_BIT]) begin
            status_q[mcc_pkg::MCC_IRQ_WAKE_BIT] <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         mask_q <= mcc_pkg::MCC_IRQ_RESET;
      end else if (wr_en && hit_mask) begin
         mask_q <= pwdata[1:0];
      end
   end

   assign irq = |(status_q & mask_q);
   assign period_irq_req = csr_q[mcc_pkg::MCC_FLAG_BIT] &&
                           csr_q[mcc_pkg::MCC_IRQ_ENABLE_BIT];
   assign period_irq_take = period_irq_req && !cpu_irq_mask;

   // ***************************************************************
   // time base divider
   // ***************************************************************
   always_comb begin
      case (tb_active_q)
         2'h0: tb_limit = mcc_pkg::MCC_TB_WIDTH'(TB_COUNT_0 - 1);
         2'h1: tb_limit = mcc_pkg::MCC_TB_WIDTH'(TB_COUNT_1 - 1);
         2'h2: tb_limit = mcc_pkg::MCC_TB_WIDTH'(TB_COUNT_2 - 1);
         default: tb_limit = mcc_pkg::MCC_TB_WIDTH'(TB_COUNT_3 - 1);
      endcase
   end

   // full halt stops the divider; wait and active halt leave it running
   assign tb_run = pwr_q != mcc_pkg::MCC_PWR_HALT;
   assign tb_done = tb_run && (tb_cnt_q == tb_limit);

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         tb_cnt_q <= '0;
      end else if (tb_done) begin
         tb_cnt_q <= '0;
      end else if (tb_run) begin
         tb_cnt_q <= tb_cnt_q + 1'b1;
      end
   end

   // selection latched only at a period boundary, avoiding a time shift
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         tb_active_q <= 2'h0;
      end else if (tb_done) begin
         tb_active_q <= csr_q[mcc_pkg::MCC_PERIOD_SEL_LSB +: 2];
      end
   end

   // ***************************************************************
   // cpu clock prescaler
   // ***************************************************************
   assign div_last = mcc_pkg::MCC_DIV_WIDTH'((5'h02 <<
                     csr_q[mcc_pkg::MCC_SLOW_DIV_LSB +: 2]) - 5'h01);

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         div_cnt_q <= '0;
         cpu_clk_en_q <= 1'b1;
      end else if (!csr_q[mcc_pkg::MCC_SLOW_SELECT_BIT]) begin
         div_cnt_q <= '0;
         cpu_clk_en_q <= 1'b1;
      end else if (div_cnt_q >= div_last) begin
         div_cnt_q <= '0;
         cpu_clk_en_q <= 1'b1;
      end else begin
         div_cnt_q <= div_cnt_q + 1'b1;
         cpu_clk_en_q <= 1'b0;
      end
   end

   assign cpu_clk_en = cpu_clk_en_q;

   // the pad mux passes sys_clk while the gate is high; no clock in fabric
   assign clock_out_enable = csr_q[mcc_pkg::MCC_CLOCK_OUT_BIT];
   assign clock_out_gate = csr_q[mcc_pkg::MCC_CLOCK_OUT_BIT];

   // ***************************************************************
   // power modes
   // ***************************************************************
   always_comb begin
      pwr_d = pwr_q;
      case (pwr_q)
         mcc_pkg::MCC_PWR_RUN: begin
            if (halt_req) begin
               if (csr_q[mcc_pkg::MCC_IRQ_ENABLE_BIT] && !auto_wakeup_halt) begin
                  pwr_d = mcc_pkg::MCC_PWR_ACTIVE_HALT;
               end else begin
                  pwr_d = mcc_pkg::MCC_PWR_HALT;
               end
            end else if (wait_req) begin
               pwr_d = mcc_pkg::MCC_PWR_WAIT;
            end
         end
         mcc_pkg::MCC_PWR_WAIT: begin
            if (period_irq_req || halt_exit_wake) begin
               pwr_d = mcc_pkg::MCC_PWR_RUN;
            end
         end
         mcc_pkg::MCC_PWR_ACTIVE_HALT: begin
            if (period_irq_req || halt_exit_wake) begin
               pwr_d = mcc_pkg::MCC_PWR_RUN;
            end
         end
         mcc_pkg::MCC_PWR_HALT: begin
            if (halt_exit_wake) begin
               pwr_d = mcc_pkg::MCC_PWR_RUN;
            end
         end
         default: pwr_d = mcc_pkg::MCC_PWR_RUN;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pwr_q <= mcc_pkg::MCC_PWR_RUN;
      end else begin
         pwr_q <= pwr_d;
      end
   end

   assign power_state = pwr_q;

   // ***************************************************************
   // checks
   // ***************************************************************
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   chk_slow_div_ratio: assert property (
      (csr_q[4] && $stable(csr_q[6:4]) && cpu_clk_en_q &&
       csr_q[6:5] == 2'h0) ##1 $stable(csr_q[6:4])
      |-> !cpu_clk_en_q ##1 cpu_clk_en_q)
      else $error("slow divide by two wrong");

   chk_normal_full_rate: assert property (
      !csr_q[4] |=> cpu_clk_en_q)
      else $error("cpu clock enable not constant in normal mode");

   chk_clock_out_pin: assert property (
      clock_out_gate == csr_q[7] && clock_out_enable == csr_q[7])
      else $error("clock out does not follow its bit");

   chk_period_restart: assert property (
      tb_done |=> tb_cnt_q == '0)
      else $error("divider not restarted at period end");

   chk_select_holds: assert property (
      !tb_done |=> $stable(tb_active_q))
      else $error("period selection changed mid period");

   chk_flag_set: assert property (
      tb_done |=> csr_q[0])
      else $error("flag not set at period end");

   chk_flag_read_clear: assert property (
      rd_csr && !tb_done |=> !csr_q[0])
      else $error("flag not cleared by read");

   chk_irq_request: assert property (
      period_irq_take |-> csr_q[0] && csr_q[1] && !cpu_irq_mask)
      else $error("interrupt taken without cause");

   chk_active_halt_entry: assert property (
      pwr_q == mcc_pkg::MCC_PWR_RUN && halt_req && csr_q[1] &&
      !auto_wakeup_halt |=> pwr_q == mcc_pkg::MCC_PWR_ACTIVE_HALT)
      else $error("active halt not entered");

   chk_wait_exit: assert property (
      pwr_q == mcc_pkg::MCC_PWR_WAIT && period_irq_req
      |=> pwr_q == mcc_pkg::MCC_PWR_RUN)
      else $error("period interrupt did not end wait");

   chk_active_halt_frozen: assert property (
      pwr_q == mcc_pkg::MCC_PWR_ACTIVE_HALT |=> $stable(csr_q[7:1]) &&
      $stable(mask_q))
      else $error("registers moved in active halt");

   chk_halt_frozen: assert property (
      pwr_q == mcc_pkg::MCC_PWR_HALT && $past(pwr_q) == mcc_pkg::MCC_PWR_HALT
      |-> $stable(tb_cnt_q) && $stable(csr_q))
      else $error("counter or register moved in halt");

   chk_no_halt_wake: assert property (
      pwr_q == mcc_pkg::MCC_PWR_HALT && !halt_exit_wake
      |=> pwr_q == mcc_pkg::MCC_PWR_HALT)
      else $error("full halt left without wake source");

   chk_reset_value: assert property (
      $past(rst) |-> csr_q == mcc_pkg::MCC_CSR_RESET && tb_cnt_q == '0)
      else $error("register not at reset value");

   cov_period_elapsed: cover property (tb_done ##[1:8] rd_csr);
   cov_active_halt_wake: cover property (
      pwr_q == mcc_pkg::MCC_PWR_ACTIVE_HALT ##1 pwr_q == mcc_pkg::MCC_PWR_RUN);
   cov_slow_sixteen: cover property (csr_q[6:4] == 3'h7 && cpu_clk_en_q);
   cov_select_change: cover property (tb_done && $changed(tb_active_q) == 1'b0
      ##1 $changed(tb_active_q));

endmodule : mcc_timebase

// ---- dv/mcc_cpu_model.sv ----
`timescale 1ns/1ns
// ***************************************************************
// cpu core and power request model
// ***************************************************************
module mcc_cpu_model (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic cmd_wait,
   input wire logic cmd_halt,
   input wire logic cmd_wake,
   input wire logic cpu_clk_en,
   output logic wait_req,
   output logic halt_req,
   output logic halt_exit_wake,
   output logic [15:0] cpu_ticks
);
   // requests are registered so they change just after an edge
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wait_req <= 1'b0;
         halt_req <= 1'b0;
         halt_exit_wake <= 1'b0;
      end else begin
         wait_req <= cmd_wait;
         halt_req <= cmd_halt;
         halt_exit_wake <= cmd_wake;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cpu_ticks <= 16'h0000;
      end else if (cpu_clk_en) begin
         cpu_ticks <= cpu_ticks + 16'h0001;
      end
   end
endmodule : mcc_cpu_model

// ---- dv/main_clock_ctrl_timebase_tb.sv ----
`timescale 1ns/1ns
module main_clock_ctrl_timebase_tb;
   // ***************************************************************
   // signals
   // ***************************************************************
   localparam int C0 = 16;
   localparam int C1 = 32;
   localparam int C2 = 80;
   localparam int C3 = 200;
   localparam logic [11:0] CSR = mcc_pkg::MCC_CSR_ADDR;
   localparam logic [11:0] STA = mcc_pkg::MCC_IRQ_STATUS_ADDR;
   localparam logic [11:0] MSK = mcc_pkg::MCC_IRQ_MASK_ADDR;
   logic sys_clk, rst, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic wait_req, halt_req, auto_wakeup_halt, halt_exit_wake, err;
   logic cpu_irq_mask, cpu_clk_en, clock_out_enable, clock_out_gate;
   logic period_irq_req, period_irq_take, irq;
   logic cmd_wait, cmd_halt, cmd_wake;
   logic [1:0] power_state;
   logic [15:0] cpu_ticks;
   int miscompares = 0;
   int check_count = 0;
   int cyc = 0;
   int tb_cnt[4] = '{C0, C1, C2, C3};

   mcc_timebase #(.TB_COUNT_0(C0), .TB_COUNT_1(C1), .TB_COUNT_2(C2),
      .TB_COUNT_3(C3)) dut (.sys_clk(sys_clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .wait_req(wait_req), .halt_req(halt_req),
      .auto_wakeup_halt(auto_wakeup_halt), .halt_exit_wake(halt_exit_wake),
      .cpu_irq_mask(cpu_irq_mask), .cpu_clk_en(cpu_clk_en),
      .clock_out_enable(clock_out_enable), .clock_out_gate(clock_out_gate),
      .period_irq_req(period_irq_req), .period_irq_take(period_irq_take),
      .irq(irq), .power_state(power_state));

   mcc_cpu_model cpu (.sys_clk(sys_clk), .rst(rst), .cmd_wait(cmd_wait),
      .cmd_halt(cmd_halt), .cmd_wake(cmd_wake), .cpu_clk_en(cpu_clk_en),
      .wait_req(wait_req), .halt_req(halt_req),
      .halt_exit_wake(halt_exit_wake), .cpu_ticks(cpu_ticks));

   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
   end

   // ***************************************************************
   // shared tasks
   // ***************************************************************
   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", what, exp, got);
         miscompares++;
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd);
      int n = 0;
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rdchk(input string what, input logic [11:0] a,
                        input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(what, exp, rd);
   endtask : rdchk

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : tick

   task automatic send(input logic [2:0] c);
      @(posedge sys_clk);
      {cmd_wake, cmd_halt, cmd_wait} <= c;
      @(posedge sys_clk);
      {cmd_wake, cmd_halt, cmd_wait} <= 3'h0;
   endtask : send

   // waits are bounded so a dead counter shows as a miss, not a hang
   task automatic wait_rise(output int t);
      int n = 0;
      @(posedge sys_clk);
      while (period_irq_req !== 1'b1 && n < 400) begin
         @(posedge sys_clk);
         n++;
      end
      t = cyc;
      chk("flag rise", 32'h1, 32'(period_irq_req));
   endtask : wait_rise

   task automatic wait_pwr(input logic [1:0] exp);
      int n = 0;
      while (power_state !== exp && n < 400) begin
         @(posedge sys_clk);
         n++;
      end
      chk("power state", 32'(exp), 32'(power_state));
   endtask : wait_pwr

   // ***************************************************************
   // scenarios
   // ***************************************************************
   task automatic t_reset;
      rdchk("csr reset", CSR, 32'h0);
      rdchk("status reset", STA, 32'h0);
      rdchk("mask reset", MSK, 32'h0);
      rdchk("power reset", mcc_pkg::MCC_POWER_ADDR, 32'h0);
      apb(1'b0, 12'h004, 32'h0);
      chk("unmapped error", 32'h1, 32'(err));
   endtask : t_reset

   task automatic t_slow;
      int t0;
      for (int c = 0; c < 5; c++) begin
         apb(1'b1, CSR, (c < 4) ? 32'(16 | (c << 5)) : 32'h0);
         tick(2);
         t0 = cpu_ticks;
         tick(64);
         chk("cpu ticks", (c < 4) ? 32'(64 >> (c + 1)) : 32'h40,
             32'(cpu_ticks - t0));
      end
   endtask : t_slow

   task automatic t_clkout;
      apb(1'b1, CSR, 32'h80);
      tick(1);
      rd = 32'({clock_out_enable, clock_out_gate});
      chk("clock out", 32'h3, rd);
      apb(1'b1, CSR, 32'h0);
      tick(1);
      rd = 32'({clock_out_enable, clock_out_gate});
      chk("clock out", 32'h0, rd);
   endtask : t_clkout

   task automatic t_period;
      int r0, r1, r2;
      int prev = 0;
      apb(1'b1, CSR, 32'h02);
      wait_rise(r0);
      apb(1'b0, CSR, 32'h0);
      wait_rise(r0);
      rdchk("flag read", CSR, 32'h03);
      tick(1);
      chk("flag cleared", 32'h0, 32'(period_irq_req));
      for (int s = 1; s < 4; s++) begin
         apb(1'b1, CSR, 32'(2 | (s << 2)));
         wait_rise(r1);
         chk("old period", tb_cnt[prev], r1 - r0);
         apb(1'b0, CSR, 32'h0);
         wait_rise(r2);
         chk("new period", tb_cnt[s], r2 - r1);
         apb(1'b0, CSR, 32'h0);
         r0 = r2;
         prev = s;
      end
   endtask : t_period

   task automatic t_irq;
      int r;
      apb(1'b0, STA, 32'h0);
      chk("status event", 32'h1, rd & 32'h1);
      chk("irq masked", 32'h0, 32'(irq));
      apb(1'b1, MSK, 32'h1);
      tick(1);
      chk("irq unmasked", 32'h1, 32'(irq));
      apb(1'b1, STA, 32'h3);
      tick(1);
      chk("irq cleared", 32'h0, 32'(irq));
      wait_rise(r);
      cpu_irq_mask <= 1'b1;
      tick(1);
      rd = 32'({period_irq_take, period_irq_req});
      chk("take masked", 32'h1, rd);
      cpu_irq_mask <= 1'b0;
      tick(1);
      rd = 32'({period_irq_take, period_irq_req});
      chk("take open", 32'h3, rd);
      apb(1'b0, CSR, 32'h0);
      apb(1'b1, MSK, 32'h0);
      apb(1'b1, STA, 32'h3);
   endtask : t_irq

   task automatic t_power;
      int r;
      apb(1'b1, CSR, 32'h06);
      wait_rise(r);
      apb(1'b0, CSR, 32'h0);
      wait_rise(r);
      apb(1'b0, CSR, 32'h0);
      send(3'b001);
      wait_pwr(mcc_pkg::MCC_PWR_WAIT);
      wait_pwr(mcc_pkg::MCC_PWR_RUN);
      chk("wait wake", 32'h1, 32'(period_irq_req));
      apb(1'b0, STA, 32'h0);
      chk("wake event", 32'h2, rd & 32'h2);
      apb(1'b0, CSR, 32'h0);
      send(3'b010);
      wait_pwr(mcc_pkg::MCC_PWR_ACTIVE_HALT);
      apb(1'b1, CSR, 32'h80);
      rdchk("frozen csr", CSR, 32'h06);
      wait_pwr(mcc_pkg::MCC_PWR_RUN);
      rdchk("csr after wake", CSR, 32'h07);
      apb(1'b1, CSR, 32'h04);
      send(3'b010);
      wait_pwr(mcc_pkg::MCC_PWR_HALT);
      tick(100);
      chk("halt held", 32'h3, 32'(power_state));
      rdchk("halt csr", CSR, 32'h04);
      send(3'b100);
      wait_pwr(mcc_pkg::MCC_PWR_RUN);
      apb(1'b1, CSR, 32'h06);
      auto_wakeup_halt <= 1'b1;
      send(3'b010);
      wait_pwr(mcc_pkg::MCC_PWR_HALT);
      tick(100);
      chk("auto halt held", 32'h3, 32'(power_state));
      send(3'b100);
      wait_pwr(mcc_pkg::MCC_PWR_RUN);
      auto_wakeup_halt <= 1'b0;
   endtask : t_power

   // ***************************************************************
   // run control
   // ***************************************************************
   task automatic print_verdict;
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : print_verdict

   initial begin
      #80000;
      miscompares++;
      $display("[ERR] run time expected done seen timeout");
      print_verdict;
   end

   initial begin
      rst = 1'b1;
      {psel, penable, pwrite, auto_wakeup_halt, cpu_irq_mask} = 5'h00;
      {cmd_wait, cmd_halt, cmd_wake} = 3'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      t_reset;
      t_slow;
      t_clkout;
      t_period;
      t_irq;
      t_power;
      print_verdict;
   end
endmodule : main_clock_ctrl_timebase_tb
